// [sesrc_cfg.svh]
// Functional notes
// - A rising current-limit event sets its raw bit, and the masked flag shows it if enabled.
// - A rising internal oscillator fault sets its raw bit, and the masked flag shows it if enabled.
// - Writing 1 to masked flag bits 6 to 1 clears them, and writing 0 leaves them unchanged.
// - The reset cause is loaded after each reset from the sources that made it.
// - An external-pin reset leaves only the external cause bit set.
// - Any other reset cause is added to the cause bits that are already set.
// - Cause bit 5 records a reset made by regulator loss of regulation.
// - Cause bit 4 records a reset requested by software.
// - Cause bit 3 records a watchdog timeout reset.
// - Cause bit 2 records a brown-out reset and cause bit 1 a power-on reset.
// - Each masked flag is its raw bit ANDed with its mask bit; the brown-out flag is also held off while brownoutIrqOrResetSelect is set.
// - Clearing a masked flag also clears the matching raw bit.
`ifndef SESRC_CFG_SVH
`define SESRC_CFG_SVH

// ==========================================================================
// Register byte offsets.
`define SESRC_OFF_MASKED   12'h058
`define SESRC_OFF_CAUSE    12'h05C
`define SESRC_OFF_RAW      12'h100
`define SESRC_OFF_IRQSTAT  12'h104
`define SESRC_OFF_IRQEN    12'h108
`define SESRC_OFF_IRQCLR   12'h10C

// ==========================================================================
// Field positions and reset values.
`define SESRC_FLAG_BITS    7'h7E
`define SESRC_BROWNOUT_BIT 1
`define SESRC_CAUSE_EXT    6'h01
`define SESRC_RST_FLAGS    7'h00
`define SESRC_RST_CAUSE    6'h00
`define SESRC_RESP_OKAY    2'h0
`define SESRC_RESP_SLVERR  2'h2

`endif

// [sesrc_pkg.sv]
package sesrc_pkg;

  // ==========================================================================
  // Clocking and power events, laid out as in the masked flag register.
  typedef struct packed {
    logic pllLock;
    logic currentLimit;
    logic intOscFault;
    logic mainOscFault;
    logic regulatorLoss;
    logic brownout;
    logic unused;
  } sesrc_evt_t;

  // ==========================================================================
  // Reset sources, laid out as in the reset cause register.
  typedef struct packed {
    logic regulatorLossCause;
    logic softwareCause;
    logic watchdogCause;
    logic brownoutCause;
    logic powerOnCause;
    logic externalCause;
  } sesrc_cause_t;

  // ==========================================================================
  // State cleared by the system reset.
  typedef struct packed {
    logic [6:0]  evtMeta;
    logic [6:0]  evtSync;
    logic [6:0]  evtPrev;
    logic [6:0]  rawStatus;
    logic [6:0]  irqStatus;
    logic [6:0]  irqEnable;
    logic        irqLine;
    logic        loadPend;
    logic        awPend;
    logic [11:0] awAddr;
    logic        wPend;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } sesrc_state_t;

  // ==========================================================================
  // State that survives every reset except power-on.
  typedef struct packed {
    logic [5:0] causeMeta;
    logic [5:0] causeSync;
    logic [5:0] cause;
  } sesrc_keep_t;

endpackage

// [sesrc_event_reset.sv]
`timescale 1ns/1ns
`include "sesrc_cfg.svh"

module sesrc_event_reset (
  // Clock and resets.
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  pwrOnRst_n,
  // Event sources from the clock and power monitors, asynchronous levels.
  input  wire sesrc_pkg::sesrc_evt_t eventIn,
  // Reset sources from the reset controller, held across the reset.
  input  wire sesrc_pkg::sesrc_cause_t resetSrc,
  // Settings from neighbouring control registers, same clock.
  input  wire logic [6:0]            eventMaskRegister,
  input  wire logic                  brownoutIrqOrResetSelect,
  // AXI4-Lite write address channel.
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [11:0]           s_axi_awaddr,
  // AXI4-Lite write data channel.
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [11:0]           s_axi_araddr,
  // AXI4-Lite read data channel.
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Status outputs.
  output logic [6:0]                 rawEventStatus,
  output logic [5:0]                 resetCause,
  output logic                       irq
);

  // ==========================================================================
  // State registers and their next values.
  sesrc_pkg::sesrc_state_t st_r;
  sesrc_pkg::sesrc_state_t st_nxt;
  sesrc_pkg::sesrc_keep_t  kp_r;
  sesrc_pkg::sesrc_keep_t  kp_nxt;

  // ==========================================================================
  // Working signals of the combinational process.
  logic [6:0]  evtRise;
  logic [6:0]  flagGate;
  logic [6:0]  maskedFlags;
  logic [6:0]  maskedNew;
  logic [6:0]  flagClear;
  logic [6:0]  irqClear;
  logic        doWrite;
  logic        lowLane;
  logic        wrHit;
  logic        doRead;
  logic [31:0] rdWord;
  logic        rdHit;

  // ==========================================================================
  // Handshake outputs follow the pending and valid flags directly.
  assign s_axi_awready = ~st_r.awPend;
  assign s_axi_wready  = ~st_r.wPend;
  assign s_axi_arready = ~st_r.rValid;

  // Data and response outputs come straight from flip-flops.
  assign s_axi_bvalid   = st_r.bValid;
  assign s_axi_bresp    = st_r.bResp;
  assign s_axi_rvalid   = st_r.rValid;
  assign s_axi_rdata    = st_r.rData;
  assign s_axi_rresp    = st_r.rResp;
  assign rawEventStatus = st_r.rawStatus;
  assign resetCause     = kp_r.cause;
  assign irq            = st_r.irqLine;

  // ==========================================================================
  // Event flags, register bus and reset cause capture.
  always_comb begin
    st_nxt = st_r;
    kp_nxt = kp_r;

    // Two flip-flops bring the monitor levels into the clock domain.
    st_nxt.evtMeta = eventIn;
    st_nxt.evtSync = st_r.evtMeta;
    st_nxt.evtPrev = st_r.evtSync;

    // The reset sources are synchronised in the power-on domain so they
    // are already settled when the system reset releases.
    kp_nxt.causeMeta = resetSrc;
    kp_nxt.causeSync = kp_r.causeMeta;

    // A flag is raised by the rising edge of its monitor, so that a fault
    // that stays present can still be cleared and reported only once.
    evtRise = st_r.evtSync & ~st_r.evtPrev & `SESRC_FLAG_BITS;

    // The brown-out flag shows only while brown-out is set to interrupt.
    flagGate = `SESRC_FLAG_BITS;
    flagGate[`SESRC_BROWNOUT_BIT] = ~brownoutIrqOrResetSelect;

    // Masked flags are the raw bits gated by their mask bits.
    maskedFlags = st_r.rawStatus & eventMaskRegister & flagGate;
    maskedNew   = evtRise & eventMaskRegister & flagGate;

    // ------------------------------------------------------------------------
    // Write channel: address and data are taken in either order and the
    // write is carried out once both are held and no response waits.
    if (s_axi_awvalid && !st_r.awPend) begin
      st_nxt.awPend = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.wPend) begin
      st_nxt.wPend = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    doWrite = st_r.awPend && st_r.wPend && !st_r.bValid;
    lowLane = st_r.wStrb[0];

    // Decode the write; all fields sit in the low byte lane.
    flagClear = 7'h00;
    irqClear  = 7'h00;
    wrHit     = 1'b0;
    if (doWrite) begin
      unique case (st_r.awAddr)
        `SESRC_OFF_MASKED: begin
          wrHit = 1'b1;
          if (lowLane) begin
            flagClear = st_r.wData[6:0] & `SESRC_FLAG_BITS;
          end
        end
        `SESRC_OFF_CAUSE: begin
          wrHit = 1'b1;
          if (lowLane) begin
            kp_nxt.cause = st_r.wData[5:0];
          end
        end
        `SESRC_OFF_RAW: begin
          wrHit = 1'b1;
        end
        `SESRC_OFF_IRQSTAT: begin
          wrHit = 1'b1;
        end
        `SESRC_OFF_IRQEN: begin
          wrHit = 1'b1;
          if (lowLane) begin
            st_nxt.irqEnable = st_r.wData[6:0] & `SESRC_FLAG_BITS;
          end
        end
        `SESRC_OFF_IRQCLR: begin
          wrHit = 1'b1;
          if (lowLane) begin
            irqClear = st_r.wData[6:0] & `SESRC_FLAG_BITS;
          end
        end
        default: begin
          wrHit = 1'b0;
        end
      endcase
      st_nxt.awPend = 1'b0;
      st_nxt.wPend  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = wrHit ? `SESRC_RESP_OKAY : `SESRC_RESP_SLVERR;
    end

    // The response stands until the master takes it.
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end

    // ------------------------------------------------------------------------
    // A cleared masked flag clears its raw bit too; only bits whose masked
    // flag is set are affected, and a new event in the same cycle wins.
    st_nxt.rawStatus = (st_r.rawStatus & ~(flagClear & maskedFlags)) | evtRise;

    // Interrupt status is sticky; a new event wins over its clear.
    st_nxt.irqStatus = (st_r.irqStatus & ~irqClear) | maskedNew;
    st_nxt.irqLine   = |(st_nxt.irqStatus & st_nxt.irqEnable);

    // ------------------------------------------------------------------------
    // Read channel: one read is held until the master takes it.
    doRead = s_axi_arvalid && !st_r.rValid;
    rdWord = 32'h0000_0000;
    rdHit  = 1'b1;
    unique case (s_axi_araddr)
      `SESRC_OFF_MASKED:  rdWord[6:0] = maskedFlags;
      `SESRC_OFF_CAUSE:   rdWord[5:0] = kp_r.cause;
      `SESRC_OFF_RAW:     rdWord[6:0] = st_r.rawStatus;
      `SESRC_OFF_IRQSTAT: rdWord[6:0] = st_r.irqStatus;
      `SESRC_OFF_IRQEN:   rdWord[6:0] = st_r.irqEnable;
      `SESRC_OFF_IRQCLR:  rdWord      = 32'h0000_0000;
      default:            rdHit       = 1'b0;
    endcase
    if (doRead) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rData  = rdWord;
      st_nxt.rResp  = rdHit ? `SESRC_RESP_OKAY : `SESRC_RESP_SLVERR;
    end else if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end

    // ------------------------------------------------------------------------
    // At the first edge after the system reset releases, the cause register
    // takes the sources that made the reset. This load wins over a write.
    // The cause state keeps running through a system reset while the pending
    // flag is held set, so the load also waits for nrst to be high; otherwise
    // the stale sources of the previous reset would be merged in.
    st_nxt.loadPend = 1'b0;
    if (st_r.loadPend && nrst) begin
      if (kp_r.causeSync[0]) begin
        kp_nxt.cause = `SESRC_CAUSE_EXT;
      end else begin
        // Regulator, software, watchdog, brown-out and power-on causes
        // sit at bits 5 down to 1 and accumulate.
        kp_nxt.cause = kp_r.cause | kp_r.causeSync;
      end
    end
  end

  // ==========================================================================
  // State cleared by the system reset.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r.evtMeta   <= `SESRC_RST_FLAGS;
      st_r.evtSync   <= `SESRC_RST_FLAGS;
      st_r.evtPrev   <= `SESRC_RST_FLAGS;
      st_r.rawStatus <= `SESRC_RST_FLAGS;
      st_r.irqStatus <= `SESRC_RST_FLAGS;
      st_r.irqEnable <= `SESRC_RST_FLAGS;
      st_r.irqLine   <= 1'b0;
      st_r.loadPend  <= 1'b1;
      st_r.awPend    <= 1'b0;
      st_r.awAddr    <= 12'h000;
      st_r.wPend     <= 1'b0;
      st_r.wData     <= 32'h0000_0000;
      st_r.wStrb     <= 4'h0;
      st_r.bValid    <= 1'b0;
      st_r.bResp     <= `SESRC_RESP_OKAY;
      st_r.rValid    <= 1'b0;
      st_r.rData     <= 32'h0000_0000;
      st_r.rResp     <= `SESRC_RESP_OKAY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Reset cause state; only a power-on reset clears it, so that causes
  // accumulate across system resets.
  always_ff @(posedge sys_clk or negedge pwrOnRst_n) begin
    if (!pwrOnRst_n) begin
      kp_r.causeMeta <= `SESRC_RST_CAUSE;
      kp_r.causeSync <= `SESRC_RST_CAUSE;
      kp_r.cause     <= `SESRC_RST_CAUSE;
    end else begin
      kp_r <= kp_nxt;
    end
  end

endmodule // sesrc_event_reset

// [sesrc_checker.sv]
`timescale 1ns/1ns
// ==========================================================================
// Port checker for the event status and reset cause block.
module sesrc_checker (
  // Clock and resets.
  input wire logic                    sys_clk,
  input wire logic                    nrst,
  input wire logic                    pwrOnRst_n,
  // Stimulus side.
  input wire sesrc_pkg::sesrc_evt_t   eventIn,
  input wire sesrc_pkg::sesrc_cause_t resetSrc,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic [11:0]             s_axi_araddr,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_rready,
  // Design side.
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_bvalid,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_rvalid,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic [6:0]              rawEventStatus,
  input wire logic [5:0]              resetCause,
  input wire logic                    irq
);
  // All checks sample on the rising clock and rest during system reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Reset cause is loaded at the first edge after release.
  property p_cause_ext;
    $rose(nrst) && pwrOnRst_n && resetSrc.externalCause |=> resetCause == 6'h01;
  endproperty
  a_cause_ext: assert property (p_cause_ext) else $error("external reset cause wrong");
  property p_cause_acc;
    $rose(nrst) && pwrOnRst_n && !resetSrc.externalCause
      |=> resetCause == ($past(resetCause) | $past(resetSrc));
  endproperty
  a_cause_acc: assert property (p_cause_acc) else $error("sticky reset cause wrong");

  // A rising event reaches the raw flag after synchronisation.
  property p_clim;
    $rose(eventIn.currentLimit) |-> ##[2:4] rawEventStatus[5];
  endproperty
  a_clim: assert property (p_clim) else $error("current limit flag not set");
  property p_iof;
    $rose(eventIn.intOscFault) |-> ##[2:4] rawEventStatus[4];
  endproperty
  a_iof: assert property (p_iof) else $error("oscillator fault flag not set");

  // Bus answers stand until taken; read data comes one cycle and the write response two cycles after the request.
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_r_err;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h200
      |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_r_err: assert property (p_r_err) else $error("unmapped read answer wrong");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");

  // Main scenarios.
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
endmodule // sesrc_checker

bind sesrc_event_reset sesrc_checker i_chk (
  .sys_clk, .nrst, .pwrOnRst_n, .eventIn, .resetSrc, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_arvalid, .s_axi_araddr, .s_axi_bready, .s_axi_rready, .s_axi_awready,
  .s_axi_wready, .s_axi_arready, .s_axi_bvalid, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_rresp, .rawEventStatus, .resetCause, .irq
);

// [sysctl_event_status_reset_cause_tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
// ==========================================================================
// Self-checking bench with a behavioural model of flags and causes.
module sysctl_event_status_reset_cause_tb;
  logic                    sys_clk = 1'h0, nrst = 1'h0, pwrOnRst_n = 1'h0;
  sesrc_pkg::sesrc_evt_t   eventIn = '0;
  sesrc_pkg::sesrc_cause_t resetSrc = 6'h02;
  logic [6:0]              eventMaskRegister = '0, rawEventStatus, me;
  logic                    brownoutIrqOrResetSelect = 1'h0, irq;
  logic                    slowAck = 1'h0;
  logic                    s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                    s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                    s_axi_rvalid;
  logic [11:0]             s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]             s_axi_wdata = '0, s_axi_rdata, seed = 32'hF508CE99, v, d;
  logic [3:0]              s_axi_wstrb = 4'hF;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic [5:0]              resetCause;
  logic [5:0]              srcs [5] = '{6'h08, 6'h10, 6'h20, 6'h04, 6'h01};
  int                      error_cnt = 0, checks = 0, cause = 0, raw = 0, ist = 0, ien = 0;

  sesrc_event_reset i_dut (
    .sys_clk, .nrst, .pwrOnRst_n, .eventIn, .resetSrc, .eventMaskRegister,
    .brownoutIrqOrResetSelect, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rawEventStatus,
    .resetCause, .irq
  );

  // The clock runs at 100 MHz.
  always #5 sys_clk = ~sys_clk;

  // Xorshift source of random stimulus.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ==========================================================================
  // Bus master tasks; each channel is released at the edge that takes it.
  // With slowAck set, the ready is raised only after the answer is seen.
  task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= !slowAck;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'h0;
        done = 1'b1;
      end else if (s_axi_bvalid) begin
        s_axi_bready <= 1'h1;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= !slowAck;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'h0;
        done = 1'b1;
      end else if (s_axi_rvalid) begin
        s_axi_rready <= 1'h1;
      end
    end
  endtask

  // Applies a reset with the given source held across it, then checks the cause.
  task automatic rst(input logic [5:0] src);
    nrst <= 1'h0;
    resetSrc <= src;
    repeat (10) @(posedge sys_clk);
    pwrOnRst_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (3) @(posedge sys_clk);
    cause = src[0] ? 1 : (cause | src);
    `CHK(resetCause, 6'(cause))
    rd(12'h05C, 32'(cause), 2'h0);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    rst(6'h02);
    for (int i = 0; i < 5; i++) rst(srcs[i]);
    wr(12'h05C, 32'hFFFFFFD5, 2'h0);
    cause = 6'h15;
    rd(12'h05C, 32'h15, 2'h0);
    rst(6'h20);
    $display("test reset_cause done");
    rd(12'h058, 32'h0, 2'h0);
    rd(12'h100, 32'h0, 2'h0);
    rd(12'h108, 32'h0, 2'h0);
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      eventMaskRegister <= v[6:0];
      brownoutIrqOrResetSelect <= v[7];
      me = v[6:0] & 7'h7E & ~{5'h0, v[7], 1'h0};
      d = rnd();
      wr(12'h108, d, 2'h0);
      ien = d & 32'h7E;
      v = rnd() & 32'h7E;
      eventIn <= v[6:0];
      repeat (6) @(posedge sys_clk);
      eventIn <= '0;
      repeat (2) @(posedge sys_clk);
      raw |= v;
      ist |= v & me;
      `CHK(rawEventStatus, 7'(raw))
      rd(12'h058, raw & me, 2'h0);
      rd(12'h104, ist, 2'h0);
      `CHK(irq, |(ist & ien))
      d = rnd();
      wr(12'h058, d, 2'h0);
      raw &= ~(d & me);
      rd(12'h058, raw & me, 2'h0);
      rd(12'h100, raw, 2'h0);
      d = rnd();
      wr(12'h10C, d, 2'h0);
      ist &= ~(d & 32'h7E);
      rd(12'h104, ist, 2'h0);
      `CHK(irq, |(ist & ien))
    end
    $display("test events done");
    slowAck = 1'h1;
    rd(12'h200, 32'h0, 2'h2);
    wr(12'h200, rnd(), 2'h2);
    slowAck = 1'h0;
    rd(12'h10C, 32'h0, 2'h0);
    s_axi_wstrb <= 4'h0;
    wr(12'h108, ~ien, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(12'h108, ien, 2'h0);
    $display("test bus done");
    give_verdict();
  end

  // Watchdog sized well beyond the thousand or fewer cycles the tests need.
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // sysctl_event_status_reset_cause_tb
